// ==== hw/ilpc_core.v ====
// Interrupt acceptance, request flags and wait/stop power control.
// Behaviour
// [R1] Acknowledge read clears accepted request flag
// [R2] Program read at zero clears top flag
// [R3] Both stack pointers reset to zero
// [R4] No acceptance during first instruction
// [R5] Non-maskable interrupt has no enable
// [R6] Function select zero makes pin port
// [R7] Low non-maskable pin forces stop bit zero
// [R8] Wait with low pin keeps clock running
// [R9] Source or polarity change may set flag
// [R10] Control bit writes may drop arrivals
// [R11] Software clears flags by plain write
// [R12] Four no-ops follow wait instruction
// [R13] Stop write needs jump and no-ops
// [R14] Clock output pin high in stop
// [R15] Port state kept in wait, stop
// [R16] Timer wake needs pulse output off
// [R17] Control bit stops peripheral clocks in wait
// [R18] Reset held until oscillator stable
// [R19] Delay interrupt enable after control write
// [R20] External pin level at least 1000 ns
// [R21] Flag holds until accepted or cleared
`timescale 1ns/1ps
`default_nettype none
`include "ilpc_map.vh"
module ilpc_core #(
   parameter integer NSRC = 8,
   parameter integer NEXT = 2,
   parameter integer CLKDIV = 4
) (
   input wire CLK_SYS_I,
   input wire SRST_I,
   input wire [7:0] ADR_I,
   input wire [31:0] DAT_I,
   output reg [31:0] DAT_O,
   input wire WE_I,
   input wire [3:0] SEL_I,
   input wire CYC_I,
   input wire STB_I,
   output reg ACK_O,
   input wire [NSRC-1:0] SRC_EVENT_I,
   input wire [NEXT-1:0] EXT_PIN_I,
   input wire NMI_PIN_I,
   input wire INSTR_DONE_I,
   input wire WAKE_I,
   output reg IRQ_VALID_O,
   output reg [7:0] IRQ_VEC_O,
   output reg NMI_REQ_O,
   output reg PORT_NMI_IN_O,
   output reg CPU_HALT_O,
   output reg CPU_CLK_EN_O,
   output reg PERIPH_CLK_EN_O,
   output reg CLOCK_OUTPUT_PIN_O,
   output reg STOP_MODE_O
);
   localparam integer EXT_MIN_CYC = `ILPC_EXT_MIN_CYC;
   localparam [2:0] S_RUN = 3'b001;
   localparam [2:0] S_WAIT = 3'b010;
   localparam [2:0] S_STOP = 3'b100;
   reg [2:0] state_q;
   reg [NSRC-1:0] req_q;
   reg [NSRC-1:0] ena_q;
   reg [NSRC-1:0] pri_q;
   reg [NEXT-1:0] pol_q;
   reg [15:0] usp_q;
   reg [15:0] isp_q;
   reg first_q;
   reg nmi_pend_q;
   reg nmi_prev_q;
   reg nmi_sel_q;
   reg pclk_stop_q;
   reg all_clock_stop_bit_q;
   reg [7:0] div_q;
   reg clk_ph_q;
   wire [NEXT-1:0] ext_evt;
   wire [NSRC-1:0] evt;
   wire acc = CYC_I & STB_I & ~ACK_O;
   wire wr = acc & WE_I & SEL_I[0];
   wire rd = acc & ~WE_I;
   wire nmi_low = nmi_sel_q & ~NMI_PIN_I;
   wire sp_ready = (isp_q != `ILPC_SP_RST);
   genvar g;
   generate
      for (g = 0; g < NEXT; g = g + 1) begin : gen_ext
         ilpc_pin_filter #(
            .MIN_CYC(EXT_MIN_CYC)
         ) u_flt (
            .clk_i(CLK_SYS_I),
            .srst_i(SRST_I),
            .pin_i(EXT_PIN_I[g]),
            .pol_i(pol_q[g]),
            .event_o(ext_evt[g])
         ); // [R20]
      end
   endgenerate
   assign evt = SRC_EVENT_I | {{(NSRC-NEXT){1'b0}}, ext_evt};
   // Highest-priority pending enabled source: high level first, then low index.
   reg found;
   reg [7:0] sel_idx;
   integer i;
   always @* begin
      found = 1'b0;
      sel_idx = 8'h00;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
         if (req_q[i] && ena_q[i] && pri_q[i]) begin
            found = 1'b1;
            sel_idx = i[7:0];
         end
      end
      if (!found) begin
         for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (req_q[i] && ena_q[i]) begin
               found = 1'b1;
               sel_idx = i[7:0];
            end
         end
      end
   end
   wire take_mask = found & ~first_q & ~IRQ_VALID_O & sp_ready; // [R4]
   wire take_nmi = nmi_pend_q & ~first_q & ~IRQ_VALID_O; // [R4] [R5]
   wire ack_rd = rd & (ADR_I == `ILPC_ACK_ADDR);
   wire [NSRC-1:0] clr_sel = (found && (ack_rd || (take_mask && !take_nmi)))
      ? ({{(NSRC-1){1'b0}}, 1'b1} << sel_idx) : {NSRC{1'b0}}; // [R1] [R2]
   wire [NSRC-1:0] clr_sw = (wr && ADR_I == `ILPC_REQ_ADDR)
      ? ~DAT_I[NSRC-1:0] : {NSRC{1'b0}}; // [R11]
   always @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         req_q <= {NSRC{1'b0}};
         ena_q <= {NSRC{1'b0}};
         pri_q <= {NSRC{1'b0}};
         pol_q <= {NEXT{1'b0}};
         usp_q <= `ILPC_SP_RST; // [R3]
         isp_q <= `ILPC_SP_RST; // [R3]
         first_q <= 1'b1;
         nmi_pend_q <= 1'b0;
         nmi_prev_q <= 1'b1;
         nmi_sel_q <= 1'b0;
         pclk_stop_q <= 1'b0;
         all_clock_stop_bit_q <= 1'b0;
         state_q <= S_RUN;
         IRQ_VALID_O <= 1'b0;
         IRQ_VEC_O <= 8'h00;
         NMI_REQ_O <= 1'b0;
         ACK_O <= 1'b0;
         DAT_O <= 32'h00000000;
      end else begin
         ACK_O <= acc; // [R19]
         // Event set wins over any clear in the same cycle.
         req_q <= (req_q & ~clr_sel & ~clr_sw) | evt; // [R21] [R9]
         if (INSTR_DONE_I) begin
            first_q <= 1'b0;
         end
         nmi_prev_q <= NMI_PIN_I;
         if (nmi_sel_q && nmi_prev_q && !NMI_PIN_I) begin
            nmi_pend_q <= 1'b1; // [R5]
         end else if (take_nmi) begin
            nmi_pend_q <= 1'b0;
         end
         IRQ_VALID_O <= 1'b0;
         NMI_REQ_O <= 1'b0;
         if (take_nmi) begin
            IRQ_VALID_O <= 1'b1;
            NMI_REQ_O <= 1'b1;
            IRQ_VEC_O <= `ILPC_NMI_VEC;
         end else if (take_mask) begin
            IRQ_VALID_O <= 1'b1;
            IRQ_VEC_O <= sel_idx;
         end
         if (wr) begin
            case (ADR_I)
               `ILPC_ENA_ADDR: ena_q <= DAT_I[NSRC-1:0]; // [R10]
               `ILPC_PRI_ADDR: pri_q <= DAT_I[NSRC-1:0];
               `ILPC_USP_ADDR: usp_q <= DAT_I[15:0];
               `ILPC_ISP_ADDR: isp_q <= DAT_I[15:0];
               `ILPC_CFG_ADDR: pol_q <= DAT_I[NEXT-1:0];
               `ILPC_PWR_ADDR: begin
                  pclk_stop_q <= DAT_I[`ILPC_PWR_PCLK];
                  nmi_sel_q <= DAT_I[`ILPC_PWR_NMISEL]; // [R6]
                  all_clock_stop_bit_q <= DAT_I[`ILPC_PWR_STOP] & ~nmi_low;
               end
               default: ;
            endcase
         end
         if (nmi_low) begin
            all_clock_stop_bit_q <= 1'b0; // [R7]
         end
         case (state_q)
            S_RUN: begin
               if (wr && ADR_I == `ILPC_PWR_ADDR) begin
                  if (DAT_I[`ILPC_PWR_STOP] && !nmi_low) begin
                     state_q <= S_STOP; // [R13]
                  end else if (DAT_I[`ILPC_PWR_WAIT]) begin
                     state_q <= S_WAIT; // [R12]
                  end
               end
            end
            S_WAIT: begin
               if (take_mask || take_nmi || WAKE_I) begin
                  state_q <= S_RUN; // [R8]
               end
            end
            S_STOP: begin
               if (take_mask || take_nmi || WAKE_I) begin
                  state_q <= S_RUN;
                  all_clock_stop_bit_q <= 1'b0;
               end
            end
            default: state_q <= S_RUN;
         endcase
         if (rd) begin
            case (ADR_I)
               `ILPC_ACK_ADDR: DAT_O <= {22'h000000, found, 1'b0, sel_idx};
               `ILPC_REQ_ADDR: DAT_O <= {{(32-NSRC){1'b0}}, req_q};
               `ILPC_ENA_ADDR: DAT_O <= {{(32-NSRC){1'b0}}, ena_q};
               `ILPC_PRI_ADDR: DAT_O <= {{(32-NSRC){1'b0}}, pri_q};
               `ILPC_USP_ADDR: DAT_O <= {16'h0000, usp_q};
               `ILPC_ISP_ADDR: DAT_O <= {16'h0000, isp_q};
               `ILPC_CFG_ADDR: DAT_O <= {{(32-NEXT){1'b0}}, pol_q};
               `ILPC_PWR_ADDR: DAT_O <= {28'h0000000, nmi_sel_q,
                  pclk_stop_q, all_clock_stop_bit_q, state_q[1]};
               `ILPC_STAT_ADDR: DAT_O <= {28'h0000000, nmi_pend_q,
                  first_q, state_q[1], state_q[2]};
               default: DAT_O <= 32'h00000000;
            endcase
         end
      end
   end
   // Clock output divider and the stop/wait controls; ports are untouched.
   always @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         div_q <= 8'h00;
         clk_ph_q <= 1'b1;
         CLOCK_OUTPUT_PIN_O <= 1'b1;
         CPU_HALT_O <= 1'b0;
         CPU_CLK_EN_O <= 1'b1;
         PERIPH_CLK_EN_O <= 1'b1;
         STOP_MODE_O <= 1'b0;
         PORT_NMI_IN_O <= 1'b1;
      end else begin
         if (div_q >= CLKDIV[7:0] - 8'h01) begin
            div_q <= 8'h00;
            clk_ph_q <= ~clk_ph_q;
         end else begin
            div_q <= div_q + 8'h01;
         end
         // A low phase is cut short when stop begins.
         CLOCK_OUTPUT_PIN_O <= state_q[2] ? 1'b1 : clk_ph_q; // [R14]
         CPU_HALT_O <= ~state_q[0]; // [R15]
         CPU_CLK_EN_O <= ~state_q[2] & (~state_q[1] | nmi_low); // [R8]
         PERIPH_CLK_EN_O <= ~state_q[2] & ~(state_q[1] & pclk_stop_q); // [R17]
         STOP_MODE_O <= state_q[2];
         PORT_NMI_IN_O <= NMI_PIN_I; // [R6]
      end
   end
endmodule
`default_nettype wire

// ==== hw/ilpc_map.vh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef ILPC_MAP_VH
`define ILPC_MAP_VH
`define ILPC_CLK_MHZ 40
`define ILPC_EXT_MIN_NS 1000
`define ILPC_EXT_MIN_CYC ((`ILPC_EXT_MIN_NS * `ILPC_CLK_MHZ + 999) / 1000)
`define ILPC_ACK_ADDR 8'h00
`define ILPC_REQ_ADDR 8'h04
`define ILPC_ENA_ADDR 8'h08
`define ILPC_PRI_ADDR 8'h0C
`define ILPC_PWR_ADDR 8'h10
`define ILPC_USP_ADDR 8'h14
`define ILPC_ISP_ADDR 8'h18
`define ILPC_CFG_ADDR 8'h1C
`define ILPC_STAT_ADDR 8'h20
`define ILPC_SP_RST 16'h0000
`define ILPC_PWR_WAIT 0
`define ILPC_PWR_STOP 1
`define ILPC_PWR_PCLK 2
`define ILPC_PWR_NMISEL 3
`define ILPC_CFG_POL 0
`define ILPC_ST_STOP 0
`define ILPC_ST_WAIT 1
`define ILPC_ST_FIRST 2
`define ILPC_ST_NMIP 3
`define ILPC_NMI_VEC 8'hFF
`endif

// ==== hw/ilpc_pin_filter.v ====
// Edge detector for one external interrupt pin with a minimum-width filter.
`timescale 1ns/1ps
`default_nettype none
module ilpc_pin_filter #(
   parameter integer MIN_CYC = 40
) (
   input wire clk_i,
   input wire srst_i,
   input wire pin_i,
   input wire pol_i,
   output reg event_o
);
   reg stable_q;
   reg [15:0] cnt_q;
   always @(posedge clk_i) begin
      if (srst_i) begin
         stable_q <= 1'b1;
         cnt_q <= 16'h0000;
         event_o <= 1'b0;
      end else begin
         event_o <= 1'b0;
         if (pin_i == stable_q) begin
            cnt_q <= 16'h0000;
         end else if (cnt_q >= MIN_CYC[15:0] - 16'h0001) begin
            // A level counts only after it held the minimum width.
            stable_q <= pin_i;
            cnt_q <= 16'h0000;
            event_o <= (pin_i == pol_i);
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/ilpc_core_props.sv ====
// Port-level assertions for the interrupt and power block.
`timescale 1ns/1ps
`default_nettype none
module ilpc_chk #(
   parameter integer CLKDIV = 4
) (
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   input wire logic INSTR_DONE_I,
   input wire logic NMI_PIN_I,
   input wire logic IRQ_VALID_O,
   input wire logic [7:0] IRQ_VEC_O,
   input wire logic NMI_REQ_O,
   input wire logic PORT_NMI_IN_O,
   input wire logic CPU_HALT_O,
   input wire logic CPU_CLK_EN_O,
   input wire logic PERIPH_CLK_EN_O,
   input wire logic CLOCK_OUTPUT_PIN_O,
   input wire logic STOP_MODE_O
);
   logic done_q;
   always_ff @(posedge CLK_SYS_I) begin
      done_q <= !SRST_I && (done_q || INSTR_DONE_I);
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   ack_next_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("ack late");
   ack_pulse_a: assert property (ACK_O |=> !ACK_O)
      else $error("ack too long");
   first_block_a: assert property (IRQ_VALID_O |-> done_q)
      else $error("accept in first instruction");
   irq_gap_a: assert property (IRQ_VALID_O |=> !IRQ_VALID_O)
      else $error("accept pulse too long");
   nmi_vector_a: assert property (NMI_REQ_O
      |-> IRQ_VALID_O && IRQ_VEC_O == 8'hFF) else $error("nmi vector");
   port_copy_a: assert property (!$past(SRST_I)
      |-> PORT_NMI_IN_O == $past(NMI_PIN_I)) else $error("port copy");
   stop_pin_a: assert property (STOP_MODE_O && $past(STOP_MODE_O)
      |-> CLOCK_OUTPUT_PIN_O) else $error("clock pin low in stop");
   stop_clk_a: assert property (STOP_MODE_O && $past(STOP_MODE_O)
      |-> CPU_HALT_O && !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
      else $error("clocks run in stop");
   wait_nmi_a: assert property ($rose(CPU_HALT_O) && !PORT_NMI_IN_O
      && !STOP_MODE_O |-> CPU_CLK_EN_O) else $error("cpu clock stopped");
   irq_c: cover property (IRQ_VALID_O);
   nmi_c: cover property (NMI_REQ_O);
   stop_c: cover property (STOP_MODE_O);
endmodule
bind ilpc_core ilpc_chk #(.CLKDIV(CLKDIV)) chk (.CLK_SYS_I, .SRST_I,
   .CYC_I, .STB_I, .ACK_O, .INSTR_DONE_I, .NMI_PIN_I, .IRQ_VALID_O,
   .IRQ_VEC_O, .NMI_REQ_O, .PORT_NMI_IN_O, .CPU_HALT_O, .CPU_CLK_EN_O,
   .PERIPH_CLK_EN_O, .CLOCK_OUTPUT_PIN_O, .STOP_MODE_O);
`default_nettype wire

// ==== verif/ilpc_src_model.sv ====
// Peripheral event sources and external pin driver.
`timescale 1ns/1ps
`default_nettype none
module ilpc_src_model (
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic [2:0] idx_i,
   input wire logic [7:0] xlen_i,
   output logic [7:0] src_o = 8'h00,
   output logic [1:0] ext_o = 2'h0
);
   logic [7:0] cnt_q = 8'h00;
   always @(posedge clk_i) begin
      src_o <= fire_i ? (8'h01 << idx_i) : 8'h00;
      if (xlen_i != 8'h00 && cnt_q == 8'h00) begin
         cnt_q <= xlen_i;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
      ext_o <= {1'b0, cnt_q != 8'h00};
   end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the interrupt and power block.
`timescale 1ns/1ps
`default_nettype none
`include "ilpc_map.vh"
module tb;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic nmi = 1'b1, done = 1'b0, wake = 1'b0, fire = 1'b0;
   logic [7:0] adr = 8'h00, xlen = 8'h00, src, vec;
   logic [31:0] wd = 32'h0, rd, q;
   logic [2:0] idx = 3'h0, k, j;
   logic [1:0] ext;
   logic ack, irq, nreq, pin, halt, cen, pen, cko, stp;
   integer err_total = 0, n_compared = 0, seed = 67361, i;
   initial forever #12.5 clk = ~clk;
   ilpc_core DUT (.CLK_SYS_I(clk), .SRST_I(rst), .ADR_I(adr), .DAT_I(wd),
      .DAT_O(rd), .WE_I(we), .SEL_I(4'hF), .CYC_I(cyc), .STB_I(stb),
      .ACK_O(ack), .SRC_EVENT_I(src), .EXT_PIN_I(ext), .NMI_PIN_I(nmi),
      .INSTR_DONE_I(done), .WAKE_I(wake), .IRQ_VALID_O(irq),
      .IRQ_VEC_O(vec), .NMI_REQ_O(nreq), .PORT_NMI_IN_O(pin),
      .CPU_HALT_O(halt), .CPU_CLK_EN_O(cen), .PERIPH_CLK_EN_O(pen),
      .CLOCK_OUTPUT_PIN_O(cko), .STOP_MODE_O(stp));
   ilpc_src_model SRC (.clk_i(clk), .fire_i(fire), .idx_i(idx),
      .xlen_i(xlen), .src_o(src), .ext_o(ext));
   function automatic [31:0] bit_of(input [2:0] n);
      bit_of = 32'h1 << n;
   endfunction
   function automatic [31:0] ackw(input [2:0] n);
      ackw = 32'h200 | n;
   endfunction
   task automatic chk(input [31:0] e, input [31:0] g);
      n_compared = n_compared + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic bus(input [7:0] a, input w, input [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w;
      wd <= d;
      i = 0;
      do begin
         @(posedge clk);
         i = i + 1;
      end while (ack !== 1'b1 && i < 20);
      chk(32'h1, ack);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic fire_src(input [2:0] n);
      @(posedge clk);
      fire <= 1'b1;
      idx <= n;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   task automatic kick(input w);
      @(posedge clk);
      wake <= w;
      done <= !w;
      @(posedge clk);
      wake <= 1'b0;
      done <= 1'b0;
      // An acceptance after the done pulse is a one-cycle pulse; return early.
      if (w) begin
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic wait_irq;
      i = 0;
      while (irq !== 1'b1 && i < 60) begin
         @(posedge clk);
         i = i + 1;
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(25 * 4000);
      err_total = err_total + 1;
      test_done;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(`ILPC_USP_ADDR, 1'b0, 32'h0);
      chk(32'h0, q);
      bus(`ILPC_ISP_ADDR, 1'b0, 32'h0);
      chk(32'h0, q);
      bus(`ILPC_CFG_ADDR, 1'b1, 32'h1);
      repeat (50) @(posedge clk);
      bus(`ILPC_REQ_ADDR, 1'b1, 32'h0);
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(32'h0, q);
      $display("reset test done");
      k = $random(seed);
      j = k + 3'h1 + {1'b0, 2'($random(seed))};
      fire_src(k);
      fire_src(j);
      repeat (10) @(posedge clk);
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(bit_of(k) | bit_of(j), q);
      bus(`ILPC_REQ_ADDR, 1'b1, ~bit_of(k));
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(bit_of(j), q);
      bus(`ILPC_ENA_ADDR, 1'b1, bit_of(k) | bit_of(j));
      bus(`ILPC_ACK_ADDR, 1'b0, 32'h0);
      chk(ackw(j), q);
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(32'h0, q);
      bus(`ILPC_ISP_ADDR, 1'b1, 32'h1 | $random(seed) & 32'hFFFF);
      fire_src(k);
      kick(1'b0);
      wait_irq;
      chk(32'h1, irq);
      chk({29'h0, k}, vec);
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(32'h0, q);
      $display("flag test done");
      bus(`ILPC_ENA_ADDR, 1'b1, 32'h0);
      bus(`ILPC_PWR_ADDR, 1'b1, 32'h8);
      @(posedge clk);
      nmi <= 1'b0;
      wait_irq;
      chk(32'h1, nreq);
      chk(32'hFF, vec);
      bus(`ILPC_PWR_ADDR, 1'b1, 32'hA);
      bus(`ILPC_PWR_ADDR, 1'b0, 32'h0);
      chk(32'h0, q & 32'h2);
      chk(32'h0, stp);
      bus(`ILPC_ENA_ADDR, 1'b1, bit_of(k));
      bus(`ILPC_PWR_ADDR, 1'b1, 32'h9);
      repeat (3) @(posedge clk);
      chk(32'h1, halt);
      chk(32'h1, cen);
      fire_src(k);
      wait_irq;
      repeat (3) @(posedge clk);
      chk(32'h0, halt);
      $display("nmi test done");
      nmi <= 1'b1;
      bus(`ILPC_PWR_ADDR, 1'b1, 32'h5);
      repeat (3) @(posedge clk);
      chk(32'h0, pen);
      kick(1'b1);
      chk(32'h1, pen);
      bus(`ILPC_PWR_ADDR, 1'b1, 32'h2);
      repeat (2) @(posedge clk);
      for (i = 0; i < 20; i = i + 1) begin
         @(posedge clk);
         chk(32'h1, cko);
      end
      chk(32'h1, stp);
      kick(1'b1);
      chk(32'h0, stp);
      nmi <= 1'b0;
      repeat (5) @(posedge clk);
      chk(32'h0, pin);
      bus(`ILPC_STAT_ADDR, 1'b0, 32'h0);
      chk(32'h0, q & 32'h8);
      nmi <= 1'b1;
      $display("power test done");
      // Keep flag 0 unaccepted so the filtered pin event stays visible.
      bus(`ILPC_ENA_ADDR, 1'b1, 32'h0);
      bus(`ILPC_REQ_ADDR, 1'b1, 32'h0);
      xlen <= 8'h14;
      @(posedge clk);
      xlen <= 8'h00;
      repeat (80) @(posedge clk);
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(32'h0, q);
      xlen <= 8'h50;
      @(posedge clk);
      xlen <= 8'h00;
      repeat (120) @(posedge clk);
      bus(`ILPC_REQ_ADDR, 1'b0, 32'h0);
      chk(32'h1, q);
      $display("pin test done");
      test_done;
   end
endmodule
`default_nettype wire
